// File: logic/pid_supervisor.sv
// Supervisor around a process regulator: gain set choice, startup hold,
// integrator control, feedback loss watch and derivative clamp.
// Assumes process values in 0.1 % steps, same-clock drive status inputs
// and terminal inputs straight from pins.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pid_supervisor_defs.svh"

module pid_supervisor
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Terminal inputs from pins
    input wire logic gain_switch_terminal,
    input wire logic integral_pause_terminal,
    // Process and drive status
    input wire logic [15:0] reference,
    input wire logic [15:0] feedback,
    input wire logic [15:0] run_frequency,
    input wire logic drive_running,
    input wire logic output_at_limit,
    input wire logic signed [15:0] derivative_raw,
    // Regulator controls
    output logic [15:0] kp_active,
    output logic [15:0] ti_active,
    output logic [15:0] td_active,
    output logic force_output,
    output logic [15:0] startup_output_preset,
    output logic integrator_enable,
    output logic regulator_enable,
    output logic signed [15:0] derivative_clamped,
    output logic feedback_loss_fault,
    output logic irq
);
    import pid_supervisor_pkg::*;

    typedef struct packed {
        logic wait_st;
        logic [31:0] rdata;
        logic [4:0] ctrl;
        logic [15:0] low_thr;
        logic [15:0] high_thr;
        logic [15:0] preset;
        logic [15:0] hold_time;
        logic [15:0] loss_thr;
        logic [15:0] loss_time;
        logic [15:0] kp1;
        logic [15:0] ti1;
        logic [15:0] td1;
        logic [15:0] kp2;
        logic [15:0] ti2;
        logic [15:0] td2;
        logic [15:0] dclamp;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic [31:0] tick_cnt;
        logic tick;
        logic [1:0] di_meta;
        logic [1:0] di_sync;
        logic run_prev;
        logic hold_active;
        logic [23:0] hold_cnt;
        logic [23:0] loss_cnt;
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] td;
        logic [15:0] span_pos;
        logic div_start;
        logic integ_en;
        logic reg_en;
        logic signed [15:0] d_out;
    } sup_regs_type;

    sup_regs_type r_reg;
    sup_regs_type r_next;

    logic [9:0] frac;
    logic frac_done;
    logic bus_wr;
    logic bus_rd;
    logic [1:0] ev_set;
    logic [15:0] dev;
    logic [15:0] a_val;
    logic [15:0] b_val;
    logic gain_two;
    gain_mode_type mode;

    frac_divider u_div
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(r_reg.div_start),
        .num(r_reg.span_pos),
        .den(16'(r_reg.high_thr - r_reg.low_thr)),
        .quot(frac),
        .done(frac_done)
    );

    // Byte lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] v;
        v = old_v;
        if (be[0])
        begin
            v[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction : merge16

    // Gain between the two sets at the given fraction
    function automatic logic [15:0] blend(input logic [15:0] g1,
                                          input logic [15:0] g2,
                                          input logic [9:0] f);
        logic signed [17:0] diff;
        logic signed [28:0] prod;
        logic signed [18:0] sum;
        diff = signed'({2'b00, g2}) - signed'({2'b00, g1});
        prod = 29'(diff) * 29'(signed'({1'b0, f}));
        sum = signed'({3'b000, g1}) + 19'(prod >>> `FRAC_BITS);
        return sum[15:0];
    endfunction : blend

    function automatic logic [31:0] read_mux(input sup_regs_type s,
                                             input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `OFS_CTRL: v = {27'h0000000, s.ctrl};
            `OFS_LOW_THR: v = {16'h0000, s.low_thr};
            `OFS_HIGH_THR: v = {16'h0000, s.high_thr};
            `OFS_PRESET: v = {16'h0000, s.preset};
            `OFS_HOLD_TIME: v = {16'h0000, s.hold_time};
            `OFS_LOSS_THR: v = {16'h0000, s.loss_thr};
            `OFS_LOSS_TIME: v = {16'h0000, s.loss_time};
            `OFS_KP1: v = {16'h0000, s.kp1};
            `OFS_TI1: v = {16'h0000, s.ti1};
            `OFS_TD1: v = {16'h0000, s.td1};
            `OFS_KP2: v = {16'h0000, s.kp2};
            `OFS_TI2: v = {16'h0000, s.ti2};
            `OFS_TD2: v = {16'h0000, s.td2};
            `OFS_DCLAMP: v = {16'h0000, s.dclamp};
            `OFS_STATUS: v = {30'h00000000, s.status};
            `OFS_MASK: v = {30'h00000000, s.mask};
            `OFS_KP_ACT: v = {16'h0000, s.kp};
            `OFS_TI_ACT: v = {16'h0000, s.ti};
            `OFS_TD_ACT: v = {16'h0000, s.td};
            `OFS_STATE: v = {28'h0000000, s.reg_en, s.integ_en, s.hold_active, s.di_sync[0]};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_mux

    always_comb
    begin
        r_next = r_reg;
        ev_set = 2'b00;
        mode = gain_mode_type'(r_reg.ctrl[`CTRL_MODE_LSB +: 2]);
        bus_wr = write && !r_reg.wait_st;
        bus_rd = read && r_reg.wait_st;
        // One wait state per access; released at the edge the master sees it low
        r_next.wait_st = !((read || write) && r_reg.wait_st);
        if (bus_rd)
        begin
            r_next.rdata = read_mux(r_reg, address);
        end

        // Pin inputs: bit 0 gain switch, bit 1 integral pause
        r_next.di_meta = {integral_pause_terminal, gain_switch_terminal};
        r_next.di_sync = r_reg.di_meta;

        // Update tick
        r_next.tick = 1'b0;
        if (r_reg.tick_cnt >= 32'(TICK_CYCLES - 1))
        begin
            r_next.tick_cnt = 32'h0000_0000;
            r_next.tick = 1'b1;
        end
        else
        begin
            r_next.tick_cnt = r_reg.tick_cnt + 32'h0000_0001;
        end

        // Deviation or frequency as the switching measure
        if (mode == MODE_FREQUENCY)
        begin
            dev = run_frequency;
        end
        else
        begin
            dev = (reference >= feedback) ? 16'(reference - feedback)
                                          : 16'(feedback - reference);
        end

        // Gain set choice
        r_next.div_start = 1'b0;
        gain_two = 1'b0;
        if (r_reg.tick)
        begin
            case (mode)
                MODE_FIXED: gain_two = 1'b0;
                MODE_TERMINAL: gain_two = r_reg.di_sync[0];
                default:
                begin
                    gain_two = dev >= r_reg.high_thr;
                    // Set two from the high threshold on; no span to divide there
                    if (dev >= r_reg.low_thr && !gain_two && r_reg.high_thr > r_reg.low_thr)
                    begin
                        r_next.span_pos = 16'(dev - r_reg.low_thr);
                        r_next.div_start = 1'b1;
                    end
                end
            endcase
            if (!r_next.div_start)
            begin
                r_next.kp = gain_two ? r_reg.kp2 : r_reg.kp1;
                r_next.ti = gain_two ? r_reg.ti2 : r_reg.ti1;
                r_next.td = gain_two ? r_reg.td2 : r_reg.td1;
            end
        end
        if (frac_done)
        begin
            r_next.kp = blend(r_reg.kp1, r_reg.kp2, frac);
            r_next.ti = blend(r_reg.ti1, r_reg.ti2, frac);
            r_next.td = blend(r_reg.td1, r_reg.td2, frac);
        end

        // Startup hold
        r_next.run_prev = drive_running;
        if (drive_running && !r_reg.run_prev)
        begin
            r_next.hold_active = 1'b1;
            r_next.hold_cnt = 24'h000000;
        end
        else if (!drive_running)
        begin
            r_next.hold_active = 1'b0;
        end
        else if (r_reg.tick && r_reg.hold_active)
        begin
            if (r_reg.hold_cnt >= 24'(r_reg.hold_time * `HOLD_TICKS_PER_UNIT))
            begin
                r_next.hold_active = 1'b0;
                ev_set[`ST_HOLD_DONE] = 1'b1;
            end
            else
            begin
                r_next.hold_cnt = r_reg.hold_cnt + 24'h000001;
            end
        end

        // Regulator and integrator enables
        r_next.reg_en = drive_running || r_reg.ctrl[`CTRL_STOPPED_RUN];
        r_next.integ_en = r_next.reg_en && !r_next.hold_active
            && !(r_reg.ctrl[`CTRL_SEPARATION] && r_reg.di_sync[1])
            && !(r_reg.ctrl[`CTRL_LIMIT_FREEZE] && output_at_limit);

        // Feedback loss watch; only counted while the regulator computes
        if (r_reg.loss_thr == 16'h0000 || !r_reg.reg_en)
        begin
            r_next.loss_cnt = 24'h000000;
        end
        else if (r_reg.tick)
        begin
            if (feedback < r_reg.loss_thr)
            begin
                if (r_reg.loss_cnt >= 24'(r_reg.loss_time * `LOSS_TICKS_PER_UNIT))
                begin
                    ev_set[`ST_LOSS_FAULT] = 1'b1;
                end
                else
                begin
                    r_next.loss_cnt = r_reg.loss_cnt + 24'h000001;
                end
            end
            else
            begin
                r_next.loss_cnt = 24'h000000;
            end
        end

        // Derivative clamp, symmetric about zero
        a_val = r_reg.dclamp;
        b_val = 16'(-signed'(r_reg.dclamp));
        if (derivative_raw > signed'(a_val))
        begin
            r_next.d_out = signed'(a_val);
        end
        else if (derivative_raw < signed'(b_val))
        begin
            r_next.d_out = signed'(b_val);
        end
        else
        begin
            r_next.d_out = derivative_raw;
        end

        // Register writes
        if (bus_wr)
        begin
            case (address)
                `OFS_CTRL:
                begin
                    if (byteenable[0])
                    begin
                        r_next.ctrl = writedata[4:0];
                    end
                end
                `OFS_LOW_THR: r_next.low_thr = merge16(r_reg.low_thr, writedata, byteenable);
                `OFS_HIGH_THR: r_next.high_thr = merge16(r_reg.high_thr, writedata, byteenable);
                `OFS_PRESET: r_next.preset = merge16(r_reg.preset, writedata, byteenable);
                `OFS_HOLD_TIME: r_next.hold_time = merge16(r_reg.hold_time, writedata, byteenable);
                `OFS_LOSS_THR: r_next.loss_thr = merge16(r_reg.loss_thr, writedata, byteenable);
                `OFS_LOSS_TIME: r_next.loss_time = merge16(r_reg.loss_time, writedata, byteenable);
                `OFS_KP1: r_next.kp1 = merge16(r_reg.kp1, writedata, byteenable);
                `OFS_TI1: r_next.ti1 = merge16(r_reg.ti1, writedata, byteenable);
                `OFS_TD1: r_next.td1 = merge16(r_reg.td1, writedata, byteenable);
                `OFS_KP2: r_next.kp2 = merge16(r_reg.kp2, writedata, byteenable);
                `OFS_TI2: r_next.ti2 = merge16(r_reg.ti2, writedata, byteenable);
                `OFS_TD2: r_next.td2 = merge16(r_reg.td2, writedata, byteenable);
                `OFS_DCLAMP: r_next.dclamp = merge16(r_reg.dclamp, writedata, byteenable);
                `OFS_MASK:
                begin
                    if (byteenable[0])
                    begin
                        r_next.mask = writedata[1:0];
                    end
                end
                default: r_next.mask = r_reg.mask;
            endcase
        end

        // Sticky status: a new event wins over a clear in the same cycle
        r_next.status = r_reg.status;
        if (bus_wr && address == `OFS_STATUS && byteenable[0])
        begin
            r_next.status = r_reg.status & ~writedata[1:0];
        end
        r_next.status = r_next.status | ev_set;
        r_next.irq = |(r_next.status & r_next.mask);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= '0;
            r_reg.wait_st <= 1'b1;
            r_reg.ctrl <= `RST_CTRL;
            r_reg.low_thr <= `RST_LOW_THR;
            r_reg.high_thr <= `RST_HIGH_THR;
            r_reg.preset <= `RST_PRESET;
            r_reg.hold_time <= `RST_HOLD_TIME;
            r_reg.loss_thr <= `RST_LOSS_THR;
            r_reg.loss_time <= `RST_LOSS_TIME;
            r_reg.kp1 <= `RST_KP;
            r_reg.ti1 <= `RST_TI;
            r_reg.td1 <= `RST_TD;
            r_reg.kp2 <= `RST_KP;
            r_reg.ti2 <= `RST_TI;
            r_reg.td2 <= `RST_TD;
            r_reg.kp <= `RST_KP;
            r_reg.ti <= `RST_TI;
            r_reg.td <= `RST_TD;
            r_reg.dclamp <= `RST_DCLAMP;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign readdata = r_reg.rdata;
    assign waitrequest = r_reg.wait_st;
    assign kp_active = r_reg.kp;
    assign ti_active = r_reg.ti;
    assign td_active = r_reg.td;
    assign force_output = r_reg.hold_active;
    assign startup_output_preset = r_reg.preset;
    assign integrator_enable = r_reg.integ_en;
    assign regulator_enable = r_reg.reg_en;
    assign derivative_clamped = r_reg.d_out;
    assign feedback_loss_fault = r_reg.status[`ST_LOSS_FAULT];
    assign irq = r_reg.irq;

endmodule : pid_supervisor

// File: logic/pid_supervisor_defs.svh
// Register offsets, field positions, reset values and timing counts for the
// regulator supervisor. Assumes a 200 MHz system clock and byte addressing.
//
// Overview of operation
// - Mode 0 fixed, 1 terminal, 2 deviation, 3 frequency
// - Terminal inactive picks set one, active set two
// - Deviation below low threshold uses set one
// - Deviation above high threshold uses set two
// - Between thresholds gains interpolate linearly
// - On start, output forced to preset value
// - After hold time, release to closed loop
// - Separation on and pause input stop integrator
// - Separation off: pause input does not stop integrator
// - Limit freeze stops integrator at output limit
// - Feedback low too long raises loss fault
// - Zero loss threshold disables loss detection
// - Stopped-state setting halts or keeps regulator
// - Derivative term clamped to derivative limit
`ifndef PID_SUPERVISOR_DEFS_SVH
`define PID_SUPERVISOR_DEFS_SVH

`define OFS_CTRL 8'h00
`define OFS_LOW_THR 8'h04
`define OFS_HIGH_THR 8'h08
`define OFS_PRESET 8'h0C
`define OFS_HOLD_TIME 8'h10
`define OFS_LOSS_THR 8'h14
`define OFS_LOSS_TIME 8'h18
`define OFS_KP1 8'h1C
`define OFS_TI1 8'h20
`define OFS_TD1 8'h24
`define OFS_KP2 8'h28
`define OFS_TI2 8'h2C
`define OFS_TD2 8'h30
`define OFS_DCLAMP 8'h34
`define OFS_STATUS 8'h38
`define OFS_MASK 8'h3C
`define OFS_KP_ACT 8'h40
`define OFS_TI_ACT 8'h44
`define OFS_TD_ACT 8'h48
`define OFS_STATE 8'h4C

`define CTRL_MODE_LSB 0
`define CTRL_SEPARATION 2
`define CTRL_LIMIT_FREEZE 3
`define CTRL_STOPPED_RUN 4

`define ST_LOSS_FAULT 0
`define ST_HOLD_DONE 1

`define RST_CTRL 5'h00
`define RST_LOW_THR 16'h00C8
`define RST_HIGH_THR 16'h0320
`define RST_PRESET 16'h0000
`define RST_HOLD_TIME 16'h0000
`define RST_LOSS_THR 16'h0000
`define RST_LOSS_TIME 16'h0000
`define RST_KP 16'h00C8
`define RST_TI 16'h00C8
`define RST_TD 16'h0000
`define RST_DCLAMP 16'h000A

`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define HOLD_UNIT_NS 10000000
`define HOLD_TICKS_PER_UNIT (`HOLD_UNIT_NS / `TICK_PERIOD_NS)
`define LOSS_UNIT_NS 100000000
`define LOSS_TICKS_PER_UNIT (`LOSS_UNIT_NS / `TICK_PERIOD_NS)
`define FRAC_BITS 10

`endif

// File: logic/pid_supervisor_pkg.sv
// Types shared by the regulator supervisor and its interpolation divider.
// Assumes the constants header is included by the modules themselves.
package pid_supervisor_pkg;

    typedef enum logic [1:0] {
        MODE_FIXED,
        MODE_TERMINAL,
        MODE_DEVIATION,
        MODE_FREQUENCY
    } gain_mode_type;

    typedef enum logic {
        DIV_IDLE,
        DIV_BUSY
    } div_state_type;

    typedef struct packed {
        div_state_type state;
        logic [3:0] step;
        logic [16:0] rem;
        logic [15:0] den;
        logic [9:0] quot;
        logic done;
    } div_regs_type;

endpackage : pid_supervisor_pkg

// File: logic/frac_divider.sv
// Serial divider giving num * 2^FRAC_BITS / den, for num below den.
// Assumes start only while idle; done pulses one cycle with the result.
`timescale 1ns/1ps
`include "pid_supervisor_defs.svh"

module frac_divider
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [15:0] num,
    input wire logic [15:0] den,
    // Result
    output logic [9:0] quot,
    output logic done
);
    import pid_supervisor_pkg::*;

    div_regs_type r_reg;
    div_regs_type r_next;
    logic [16:0] shifted;

    always_comb
    begin
        r_next = r_reg;
        r_next.done = 1'b0;
        shifted = {r_reg.rem[15:0], 1'b0};
        case (r_reg.state)
            DIV_IDLE:
            begin
                if (start)
                begin
                    r_next.state = DIV_BUSY;
                    r_next.rem = {1'b0, num};
                    r_next.den = den;
                    r_next.step = 4'h0;
                    r_next.quot = 10'h000;
                end
            end
            DIV_BUSY:
            begin
                // One quotient bit per cycle keeps the logic to one subtractor
                if (shifted >= {1'b0, r_reg.den})
                begin
                    r_next.rem = shifted - {1'b0, r_reg.den};
                    r_next.quot = {r_reg.quot[8:0], 1'b1};
                end
                else
                begin
                    r_next.rem = shifted;
                    r_next.quot = {r_reg.quot[8:0], 1'b0};
                end
                r_next.step = r_reg.step + 4'h1;
                if (r_reg.step == 4'(`FRAC_BITS - 1))
                begin
                    r_next.state = DIV_IDLE;
                    r_next.done = 1'b1;
                end
            end
            default:
            begin
                r_next.state = DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= '{DIV_IDLE, 4'h0, 17'h00000, 16'h0000, 10'h000, 1'b0};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign quot = r_reg.quot;
    assign done = r_reg.done;

endmodule : frac_divider

// File: testbench/pid_supervisor_asserts.sv
// Port checker for the regulator supervisor.
// Assumes binding into pid_supervisor; port names match the design.
`timescale 1ns/1ps

module pid_supervisor_asserts
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Drive and outputs
    input wire logic drive_running,
    input wire logic signed [15:0] derivative_raw,
    input wire logic signed [15:0] derivative_clamped,
    input wire logic [15:0] startup_output_preset,
    input wire logic force_output,
    input wire logic regulator_enable,
    input wire logic feedback_loss_fault,
    input wire logic irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("waitrequest late");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_upper_zero: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_start_forces: assert property ($rose(drive_running) |=> force_output)
        else $error("no forced output on start");
    a_stop_release: assert property (!drive_running |=> !force_output)
        else $error("forced output while stopped");
    a_run_enables: assert property (drive_running |=> regulator_enable)
        else $error("regulator off while running");
    a_fault_sticky: assert property (feedback_loss_fault && !write |=> feedback_loss_fault)
        else $error("fault dropped without clear");
    a_clamp_bound: assert property (derivative_raw >= 0 |=>
        derivative_clamped >= 0 && derivative_clamped <= $past(derivative_raw))
        else $error("derivative clamp out of range");
    a_preset_stable: assert property (waitrequest |=> $stable(startup_output_preset))
        else $error("preset changed without write");

    c_start: cover property ($rose(force_output));
    c_fault: cover property ($rose(feedback_loss_fault));
    c_irq: cover property ($fell(irq));
endmodule : pid_supervisor_asserts

bind pid_supervisor pid_supervisor_asserts pid_supervisor_asserts_i (.*);

// File: testbench/terminal_pins.sv
// Model of the digital input terminals wired to the supervisor.
// Assumes the bench sets the wanted levels; pins move on the clock edge.
`timescale 1ns/1ps

module terminal_pins
(
    // Clock
    input wire logic mclk,
    // Wanted levels
    input wire logic want_switch,
    input wire logic want_pause,
    // Pins
    output logic gain_switch_terminal,
    output logic integral_pause_terminal
);
    initial gain_switch_terminal = 1'b0;
    initial integral_pause_terminal = 1'b0;
    // Pins are real wires, so they change only at a clock edge here
    always @(posedge mclk)
    begin
        gain_switch_terminal <= want_switch;
        integral_pause_terminal <= want_pause;
    end
endmodule : terminal_pins

// File: testbench/tb_pid_supervisor.sv
// Self-checking bench for the regulator supervisor.
// Assumes TICK_CYCLES shortened to 20; all counts derived from it.
`timescale 1ns/1ps
`include "pid_supervisor_defs.svh"

module tb_pid_supervisor;
    logic mclk = 0, rst_n = 0, read = 0, write = 0, drv = 0, lim = 0, ws = 0, wp = 0;
    logic [7:0] address = 0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 0, readdata, q;
    logic waitrequest, gst, ipt, fo, ie, re, fault, irq;
    logic [15:0] ref_v = 0, fb = 16'h03E8, rf = 0, kp, ti, td, pre;
    logic signed [15:0] draw = 0, dcl;
    logic [15:0] lf = 16'hDCE6;
    int n_errors = 0, n_compared = 0;

    always #2.5 mclk = ~mclk;

    terminal_pins terminal_pins_i (.mclk(mclk), .want_switch(ws), .want_pause(wp),
        .gain_switch_terminal(gst), .integral_pause_terminal(ipt));
    pid_supervisor #(.TICK_CYCLES(20)) pid_supervisor_i (.mclk(mclk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .gain_switch_terminal(gst), .integral_pause_terminal(ipt), .reference(ref_v),
        .feedback(fb), .run_frequency(rf), .drive_running(drv), .output_at_limit(lim),
        .derivative_raw(draw), .kp_active(kp), .ti_active(ti), .td_active(td),
        .force_output(fo), .startup_output_preset(pre), .integrator_enable(ie),
        .regulator_enable(re), .derivative_clamped(dcl), .feedback_loss_fault(fault),
        .irq(irq));

    task report_and_stop;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_errors++;
            $display("ERROR %0t: got %0h want %0h", $time, s, e);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at an edge
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 0;
        read <= 0;
    endtask : acc

    task wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt

    function automatic logic [15:0] gexp(input logic [15:0] m);
        if (m > 800)
            return 16'h012C;
        if (m < 200)
            return 16'h0064;
        return 16'h0064 + ((32'd200 * (((m - 200) * 1024) / 600)) >> 10);
    endfunction : gexp

    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nx

    initial
    begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        logic [15:0] ra [6] = '{16'h0004, 16'h0008, 16'h0034, 16'h001C, 16'h0000, 16'h0050};
        logic [15:0] rv [6] = '{16'h00C8, 16'h0320, 16'h000A, 16'h00C8, 16'h0000, 16'h0000};
        logic signed [15:0] dr [3] = '{16'sd500, -16'sd500, 16'sd7};
        logic signed [15:0] de [3] = '{16'sd10, -16'sd10, 16'sd7};
        logic [15:0] d;
        wt(2);
        rst_n <= 1;
        foreach (ra[i])
        begin
            acc(0, ra[i][7:0], 0);
            chk(q, rv[i]); // Reset values, unmapped reads zero
        end
        acc(1, `OFS_KP1, 100);
        acc(1, `OFS_KP2, 300);
        acc(1, `OFS_TD1, 100);
        acc(1, `OFS_TD2, 300);
        wt(60);
        chk({ti, kp}, {16'h00C8, 16'h0064});
        acc(1, `OFS_CTRL, 1);
        ws <= 1;
        wt(60);
        chk({ti, kp}, {16'h00C8, 16'h012C});
        ws <= 0;
        wt(60);
        chk(kp, 100);
        $display("gain fixed and terminal done");
        acc(1, `OFS_CTRL, 2);
        for (int i = 0; i < 10; i++)
        begin
            lf = nx(lf);
            ref_v <= lf % 1001;
            fb <= (i == 0) ? 16'h03E8 : (nx(lf) % 1001);
            d = (i == 0) ? 16'h01F4 : 0;
            wt(60);
            d = (ref_v > fb) ? ref_v - fb : fb - ref_v;
            chk({kp, td}, {gexp(d), gexp(d)});
        end
        acc(1, `OFS_CTRL, 3);
        foreach (rv[i])
        begin
            lf = nx(lf);
            rf <= (i == 0) ? 16'h0320 : lf % 1001;
            wt(60);
            chk({kp, td}, {gexp(rf), gexp(rf)});
        end
        $display("gain automatic done");
        acc(1, `OFS_CTRL, 0);
        acc(1, `OFS_PRESET, 500);
        acc(1, `OFS_HOLD_TIME, 1);
        drv <= 1;
        wt(3);
        chk({fo, pre}, {1'b1, 16'h01F4});
        wt(150);
        chk(fo, 1);
        wt(110);
        chk({fo, ie}, 2'b01);
        acc(0, `OFS_STATUS, 0);
        chk(q[1], 1);
        $display("startup hold done");
        acc(1, `OFS_CTRL, 4);
        wp <= 1;
        wt(5);
        chk(ie, 0);
        acc(1, `OFS_CTRL, 0);
        wt(5);
        chk(ie, 1);
        wp <= 0;
        lim <= 1;
        acc(1, `OFS_CTRL, 8);
        wt(5);
        chk(ie, 0);
        acc(1, `OFS_CTRL, 0);
        wt(5);
        chk(ie, 1);
        lim <= 0;
        $display("integrator done");
        fb <= 50;
        acc(1, `OFS_MASK, 1);
        wt(300);
        chk(fault, 0);
        acc(1, `OFS_LOSS_TIME, 1);
        acc(1, `OFS_LOSS_THR, 100);
        wt(1000);
        chk(fault, 0);
        wt(1200);
        chk({fault, irq}, 2'b11);
        fb <= 500;
        acc(1, `OFS_STATUS, 1);
        wt(3);
        chk({fault, irq}, 2'b00);
        $display("feedback loss done");
        drv <= 0;
        acc(1, `OFS_CTRL, 16);
        wt(3);
        chk(re, 1);
        acc(1, `OFS_CTRL, 0);
        wt(3);
        chk(re, 0);
        foreach (dr[i])
        begin
            draw <= dr[i];
            wt(3);
            chk(dcl, de[i]);
        end
        $display("stop and clamp done");
        report_and_stop();
    end
endmodule : tb_pid_supervisor
